// [src/mjp_map.svh]
`ifndef MJP_MAP_SVH
`define MJP_MAP_SVH
// clock and motion figures
`define MJP_CLK_HZ 64'h989680
`define MJP_SEC_PER_MIN 64'h3C
`define MJP_STEP_NM 64'h2710
`define MJP_NM_PER_MM 64'hF4240
`define MJP_FAST_MM_MIN 64'h4B0
`define MJP_SLOW_MM_MIN 64'h96
`define MJP_PERIOD(r) (`MJP_CLK_HZ*`MJP_SEC_PER_MIN*`MJP_STEP_NM/((r)*`MJP_NM_PER_MM))
`define MJP_MS_PER_S 64'h3E8
`define MJP_REPEAT_MS 64'h1F4
`define MJP_SPIN_RAMP_MS 64'h64
`define MJP_MS_CYC(t) (`MJP_CLK_HZ*(t)/`MJP_MS_PER_S)
`define MJP_DECEL_STEPS 3'h4
// override limits, percent
`define MJP_OVR_MIN 7'h00
`define MJP_OVR_MAX 7'h6E
`define MJP_OVR_NOM 7'h64
`define MJP_OVR_STEP 7'h05
`define MJP_PCT_DIV 18'h00064
`define MJP_TENS 11'h00A
// spindle limits, rpm
`define MJP_SPIN_MIN 12'h000
`define MJP_SPIN_MAX 12'h7D0
`define MJP_SPIN_STEP 12'h00A
`endif

// [src/mjp_pkg.sv]
package mjp_pkg;
   typedef enum logic [2:0] {M_IDLE, M_RUN, M_HALT, M_MANUAL, M_SIM} mjp_mode_t;
   typedef enum logic [1:0] {JOG_FAST, JOG_SLOW, JOG_STEP} mjp_rate_t;
   typedef struct packed {
      logic start; logic stop; logic manual_select_key;
      logic left; logic right; logic up; logic down;
      logic feed_dec; logic feed_inc; logic spin_dec; logic spin_inc;
      logic spin_start; logic spin_stop;
   } mjp_keys_t;
   typedef struct packed {
      logic manual; mjp_rate_t rate; logic feed_valid;
      logic [10:0] prog_feed; logic [10:0] ovr_feed;
   } mjp_disp_t;
   typedef struct packed {
      logic x_step; logic x_toward; logic z_step; logic z_toward;
   } mjp_axis_t;
   function automatic mjp_rate_t mjp_rate_succ(input mjp_rate_t r);
      unique case (r)
         JOG_FAST: mjp_rate_succ = JOG_SLOW;
         JOG_SLOW: mjp_rate_succ = JOG_STEP;
         default: mjp_rate_succ = JOG_FAST;
      endcase
   endfunction
endpackage

// [src/mjp_sat_ctr.sv]
`timescale 1ns/1ns
`default_nettype none
module mjp_sat_ctr #(
   parameter int W = 7,
   parameter logic [W-1:0] MIN = '0,
   parameter logic [W-1:0] MAX = '1,
   parameter logic [W-1:0] STEP = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic inc_in,
   input wire logic dec_in,
   input wire logic load_in,
   input wire logic [W-1:0] load_val_in,
   output logic [W-1:0] val_out
);
   logic [W-1:0] val_r, val_nxt;
   always_comb begin
      val_nxt = val_r;
      if (load_in) begin
         // a programmed value outside the limits is clamped, never taken as is
         val_nxt = (load_val_in > MAX) ? MAX : ((load_val_in < MIN) ? MIN : load_val_in);
      end else if (inc_in && !dec_in) begin
         val_nxt = (val_r > MAX - STEP) ? MAX : val_r + STEP;
      end else if (dec_in && !inc_in) begin
         val_nxt = (val_r < MIN + STEP) ? MIN : val_r - STEP;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) val_r <= RST;
      else val_r <= val_nxt;
   end
   assign val_out = val_r;
   a_ctr_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      val_r >= MIN && val_r <= MAX)
      else $error("counter left its range");
endmodule // mjp_sat_ctr
`default_nettype wire

// [src/mjp_axis_jog.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mjp_map.svh"
module mjp_axis_jog import mjp_pkg::*; #(
   parameter int CW = 24,
   parameter int unsigned FAST_CYC = 5000,
   parameter int unsigned SLOW_CYC = 40000
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic en_in,
   input wire mjp_rate_t rate_in,
   input wire logic toward_in,
   input wire logic away_in,
   output logic step_out,
   output logic toward_out
);
   typedef enum logic [1:0] {A_IDLE, A_RUN, A_DECEL} mjp_ast_t;
   mjp_ast_t st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt, base;
   logic [2:0] dn_r, dn_nxt;
   logic held, held_r, step_r, step_nxt, dir_r, dir_nxt;
   assign held = toward_in | away_in;
   assign base = (rate_in == JOG_SLOW) ? CW'(SLOW_CYC) : CW'(FAST_CYC);
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      dn_nxt = dn_r;
      dir_nxt = dir_r;
      step_nxt = 1'h0;
      unique case (st_r)
         A_IDLE: if (en_in && held && !held_r) begin
            dir_nxt = toward_in;
            step_nxt = 1'h1;
            if (rate_in != JOG_STEP) begin
               st_nxt = A_RUN;
               cnt_nxt = base - CW'(1);
            end
         end
         A_RUN: if (!held || !en_in) begin
            st_nxt = A_DECEL;
            dn_nxt = 3'h0;
            cnt_nxt = (base << 1) - CW'(1);
         end else if (cnt_r == '0) begin
            step_nxt = 1'h1;
            cnt_nxt = base - CW'(1);
         end else begin
            cnt_nxt = cnt_r - CW'(1);
         end
         // each trailing step waits twice as long as the one before
         A_DECEL: if (cnt_r == '0) begin
            step_nxt = 1'h1;
            dn_nxt = dn_r + 3'h1;
            cnt_nxt = CW'(base << (dn_r + 3'h2)) - CW'(1);
            if (dn_r == `MJP_DECEL_STEPS - 3'h1) st_nxt = A_IDLE;
         end else begin
            cnt_nxt = cnt_r - CW'(1);
         end
      endcase
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= A_IDLE;
         cnt_r <= '0;
         dn_r <= 3'h0;
         held_r <= 1'h0;
         step_r <= 1'h0;
         dir_r <= 1'h0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         dn_r <= dn_nxt;
         held_r <= held;
         step_r <= step_nxt;
         dir_r <= dir_nxt;
      end
   end
   assign step_out = step_r;
   assign toward_out = dir_r;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_release_decel: assert property ((st_r == A_RUN && !held) |=> st_r == A_DECEL)
      else $error("release did not start deceleration");
   a_step_single: assert property ((st_r == A_IDLE && rate_in == JOG_STEP && held_r)
      |=> !step_r)
      else $error("held key gave more than one increment");
endmodule // mjp_axis_jog
`default_nettype wire

// [src/mjp_panel.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mjp_map.svh"
module mjp_panel import mjp_pkg::*; #(
   parameter int unsigned FAST_CYC = 32'(`MJP_PERIOD(`MJP_FAST_MM_MIN)),
   parameter int unsigned SLOW_CYC = 32'(`MJP_PERIOD(`MJP_SLOW_MM_MIN)),
   parameter int unsigned REPEAT_CYC = 32'(`MJP_MS_CYC(`MJP_REPEAT_MS)),
   parameter int unsigned SPIN_RAMP_CYC = 32'(`MJP_MS_CYC(`MJP_SPIN_RAMP_MS)),
   parameter int CW = 24
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire mjp_keys_t keys_in,
   input wire logic sim_req_in,
   input wire logic prog_end_in,
   input wire logic block_done_in,
   input wire logic spin_prog_load_in,
   input wire logic [10:0] prog_feed_in,
   input wire logic [11:0] prog_spin_in,
   output mjp_mode_t mode_out,
   output mjp_disp_t disp_out,
   output logic [10:0] feed_out,
   output logic [11:0] spin_speed_out,
   output logic spin_on_out,
   output logic sim_fast_out,
   output mjp_axis_t axis_out
);
   // reset release through two flops
   logic rst_meta_r, rst_n_r;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_r <= 1'h0;
         rst_n_r <= 1'h0;
      end else begin
         rst_meta_r <= 1'h1;
         rst_n_r <= rst_meta_r;
      end
   end

   // key press edges; inputs taken as already synchronous
   mjp_keys_t keys_r, keys_nxt, press;
   assign press = mjp_keys_t'(keys_in & ~keys_r);
   always_comb begin
      keys_nxt = keys_in;
   end
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) keys_r <= '0;
      else keys_r <= keys_nxt;
   end

   // operating mode and jog rate
   mjp_mode_t mode_r, mode_nxt;
   mjp_rate_t rate_r, rate_nxt;
   logic [CW-1:0] rep_r, rep_nxt;
   logic rep_tick;
   assign rep_tick = (mode_r == M_MANUAL) && keys_r.manual_select_key
      && keys_in.manual_select_key && (rep_r == CW'(REPEAT_CYC - 1));
   always_comb begin
      mode_nxt = mode_r;
      rate_nxt = rate_r;
      rep_nxt = '0;
      unique case (mode_r)
         M_IDLE: begin
            if (press.start) mode_nxt = M_RUN;
            else if (sim_req_in) mode_nxt = M_SIM;
         end
         M_RUN: begin
            if (press.stop) mode_nxt = M_HALT;
            else if (prog_end_in) mode_nxt = M_IDLE;
         end
         M_HALT: begin
            if (press.start) begin
               mode_nxt = M_RUN;
            end else if (press.manual_select_key) begin
               mode_nxt = M_MANUAL;
               rate_nxt = JOG_FAST;
            end
         end
         M_MANUAL: begin
            if (press.stop) begin
               mode_nxt = M_IDLE;
            end else if (press.manual_select_key || rep_tick) begin
               rate_nxt = mjp_rate_succ(rate_r);
            end
            // repeat timer runs only while the key stays down
            if (keys_in.manual_select_key && !press.manual_select_key && !rep_tick)
               rep_nxt = rep_r + CW'(1);
         end
         M_SIM: begin
            if (press.stop) mode_nxt = M_IDLE;
         end
         default: mode_nxt = M_IDLE;
      endcase
   end
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r <= M_IDLE;
         rate_r <= JOG_FAST;
         rep_r <= '0;
      end else begin
         mode_r <= mode_nxt;
         rate_r <= rate_nxt;
         rep_r <= rep_nxt;
      end
   end
   assign mode_out = mode_r;

   // feed override percentage
   logic [6:0] pct_w;
   logic run;
   assign run = (mode_r == M_RUN);
   mjp_sat_ctr #(
      .W(7),
      .MIN(`MJP_OVR_MIN),
      .MAX(`MJP_OVR_MAX),
      .STEP(`MJP_OVR_STEP),
      .RST(`MJP_OVR_NOM)
   ) u_feed_ovr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_r),
      .inc_in(run && press.feed_inc),
      .dec_in(run && press.feed_dec),
      .load_in(block_done_in),
      .load_val_in(`MJP_OVR_NOM),
      .val_out(pct_w)
   );
   logic [17:0] feed_prod;
   logic [10:0] feed_ovr;
   assign feed_prod = prog_feed_in * pct_w;
   assign feed_ovr = 11'(feed_prod / `MJP_PCT_DIV);

   // spindle speed: held key ramps while running, value kept until a block reloads it
   logic [CW-1:0] ramp_r, ramp_nxt;
   logic ramp_tick, spin_held;
   logic [11:0] spin_w;
   assign spin_held = run && (keys_in.spin_inc ^ keys_in.spin_dec);
   assign ramp_tick = spin_held && (ramp_r == CW'(SPIN_RAMP_CYC - 1));
   always_comb begin
      ramp_nxt = '0;
      if (spin_held && !ramp_tick) ramp_nxt = ramp_r + CW'(1);
   end
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) ramp_r <= '0;
      else ramp_r <= ramp_nxt;
   end
   mjp_sat_ctr #(
      .W(12),
      .MIN(`MJP_SPIN_MIN),
      .MAX(`MJP_SPIN_MAX),
      .STEP(`MJP_SPIN_STEP),
      .RST(`MJP_SPIN_MIN)
   ) u_spin_ovr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_r),
      .inc_in(ramp_tick && keys_in.spin_inc),
      .dec_in(ramp_tick && keys_in.spin_dec),
      .load_in(spin_prog_load_in),
      .load_val_in(prog_spin_in),
      .val_out(spin_w)
   );

   // spindle run, simulation speed, outputs to drives and display
   logic spin_on_r, spin_on_nxt, sim_fast_r, sim_fast_nxt;
   logic [10:0] feed_r, feed_nxt;
   logic [11:0] spin_r, spin_nxt;
   mjp_disp_t disp_r, disp_nxt;
   always_comb begin
      spin_on_nxt = spin_on_r;
      // stop wins when both buttons land together
      if (press.spin_stop) spin_on_nxt = 1'h0;
      else if (press.spin_start) spin_on_nxt = 1'h1;
      sim_fast_nxt = sim_fast_r;
      if (mode_r == M_SIM && press.feed_inc && !press.feed_dec)
         sim_fast_nxt = 1'h1;
      else if (mode_r == M_SIM && press.feed_dec && !press.feed_inc)
         sim_fast_nxt = 1'h0;
      feed_nxt = feed_ovr;
      spin_nxt = spin_w;
      disp_nxt.manual = (mode_r == M_MANUAL);
      disp_nxt.rate = rate_r;
      disp_nxt.feed_valid = run;
      // display drops the units digit, so small overrides may not show
      disp_nxt.prog_feed = (prog_feed_in / `MJP_TENS) * `MJP_TENS;
      disp_nxt.ovr_feed = (feed_ovr / `MJP_TENS) * `MJP_TENS;
   end
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         spin_on_r <= 1'h0;
         sim_fast_r <= 1'h0;
         feed_r <= 11'h000;
         spin_r <= 12'h000;
         disp_r <= '0;
      end else begin
         spin_on_r <= spin_on_nxt;
         sim_fast_r <= sim_fast_nxt;
         feed_r <= feed_nxt;
         spin_r <= spin_nxt;
         disp_r <= disp_nxt;
      end
   end
   assign spin_on_out = spin_on_r;
   assign sim_fast_out = sim_fast_r;
   assign feed_out = feed_r;
   assign spin_speed_out = spin_r;
   assign disp_out = disp_r;

   // manual jog, one axis each
   logic jog_en;
   assign jog_en = (mode_r == M_MANUAL);
   mjp_axis_jog #(
      .CW(CW),
      .FAST_CYC(FAST_CYC),
      .SLOW_CYC(SLOW_CYC)
   ) u_z_axis (
      .clk_in(clk_in),
      .rst_n_in(rst_n_r),
      .en_in(jog_en),
      .rate_in(rate_r),
      .toward_in(keys_in.left),
      .away_in(keys_in.right),
      .step_out(axis_out.z_step),
      .toward_out(axis_out.z_toward)
   );
   mjp_axis_jog #(
      .CW(CW),
      .FAST_CYC(FAST_CYC),
      .SLOW_CYC(SLOW_CYC)
   ) u_x_axis (
      .clk_in(clk_in),
      .rst_n_in(rst_n_r),
      .en_in(jog_en),
      .rate_in(rate_r),
      .toward_in(keys_in.up),
      .away_in(keys_in.down),
      .step_out(axis_out.x_step),
      .toward_out(axis_out.x_toward)
   );

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_r);
   a_manual_entry: assert property ((mode_r == M_MANUAL && $past(mode_r) != M_MANUAL)
      |-> $past(mode_r) == M_HALT)
      else $error("manual entered without program stopped");
   a_entry_fast: assert property ((mode_r == M_MANUAL && $past(mode_r) != M_MANUAL)
      |-> rate_r == JOG_FAST ##1 disp_r.rate == JOG_FAST)
      else $error("manual did not start in fast jog");
   a_rate_cycle: assert property ((mode_r == M_MANUAL && press.manual_select_key
      && !press.stop) |=> rate_r == mjp_rate_succ($past(rate_r)))
      else $error("jog rate did not advance");
   a_rate_repeat: assert property ((mode_r == M_MANUAL && rep_tick && !press.stop)
      |=> rate_r != $past(rate_r))
      else $error("held manual key did not repeat");
   a_feed_still: assert property ((!run && !block_done_in) |=> $stable(pct_w))
      else $error("feed override moved outside execution");
   a_feed_restore: assert property (block_done_in |=> pct_w == `MJP_OVR_NOM)
      else $error("feed not restored after block");
   a_feed_tens: assert property (disp_r.ovr_feed % `MJP_TENS == 11'h000)
      else $error("shown feed not in tens");
   a_sim_fast: assert property ((mode_r == M_SIM && press.feed_inc && !press.feed_dec)
      |=> sim_fast_r)
      else $error("simulation speed not set fast");
   a_spin_stop: assert property ((run && press.spin_stop && !press.stop && !prog_end_in)
      |=> !spin_on_r && mode_r == M_RUN)
      else $error("spindle stop disturbed the program");
   a_spin_start: assert property ((press.spin_start && !press.spin_stop) |=> spin_on_r)
      else $error("spindle did not start");
   a_stop_halts: assert property ((run && press.stop) |=> mode_r == M_HALT)
      else $error("stop key did not halt");
   a_halt_entry: assert property ((mode_r == M_HALT && $past(mode_r) != M_HALT)
      |-> $past(mode_r) == M_RUN)
      else $error("halt entered from outside execution");
   a_resume: assert property ((mode_r == M_HALT && press.start) |=> mode_r == M_RUN)
      else $error("start key did not resume");
   a_manual_shown: assert property (mode_r == M_MANUAL |=> disp_r.manual)
      else $error("manual operation not shown");
   a_rate_shown: assert property (disp_r.rate == $past(rate_r))
      else $error("shown jog rate lags");
   a_rep_idle: assert property (!keys_in.manual_select_key |=> rep_r == CW'(0))
      else $error("repeat timer ran with key up");
   a_feed_inc: assert property ((run && press.feed_inc && !press.feed_dec)
      && !block_done_in |=> pct_w > $past(pct_w) || pct_w == `MJP_OVR_MAX)
      else $error("feed increase had no effect");
   a_feed_dec: assert property ((run && press.feed_dec && !press.feed_inc)
      && !block_done_in |=> pct_w < $past(pct_w) || pct_w == `MJP_OVR_MIN)
      else $error("feed decrease had no effect");
   a_feed_top: assert property (pct_w <= `MJP_OVR_MAX)
      else $error("feed override above its limit");
   a_feed_shown: assert property (disp_r.feed_valid == $past(run))
      else $error("feed display not tied to execution");
   a_prog_tens: assert property (disp_r.prog_feed % `MJP_TENS == 11'h000)
      else $error("shown programmed feed not in tens");
   a_spin_kept: assert property ((!spin_held && !spin_prog_load_in)
      |=> $stable(spin_w))
      else $error("spindle speed drifted with keys up");
   a_spin_load: assert property ((spin_prog_load_in && prog_spin_in <= `MJP_SPIN_MAX)
      |=> spin_w == $past(prog_spin_in))
      else $error("programmed spindle speed not taken");
   a_spin_up: assert property ((ramp_tick && keys_in.spin_inc && !spin_prog_load_in)
      |=> spin_w > $past(spin_w) || spin_w == `MJP_SPIN_MAX)
      else $error("held increase did not raise spindle");
   a_spin_down: assert property ((ramp_tick && keys_in.spin_dec && !spin_prog_load_in)
      |=> spin_w < $past(spin_w) || spin_w == `MJP_SPIN_MIN)
      else $error("held decrease did not lower spindle");
   a_spin_off: assert property (press.spin_stop |=> !spin_on_r)
      else $error("spindle did not stop");
   a_sim_only: assert property (mode_r != M_SIM |=> $stable(sim_fast_r))
      else $error("simulation speed moved outside simulation");
   a_sim_slow: assert property ((mode_r == M_SIM && press.feed_dec && !press.feed_inc)
      |=> !sim_fast_r)
      else $error("simulation speed not set slow");
   c_spin_ramp: cover property (run && ramp_tick);
   c_manual_step: cover property (mode_r == M_MANUAL && rate_r == JOG_STEP
      && axis_out.z_step);
   c_feed_max: cover property (run && pct_w == `MJP_OVR_MAX);
   c_resume: cover property (mode_r == M_HALT ##1 mode_r == M_RUN);
   c_sim_slow: cover property (mode_r == M_SIM && $fell(sim_fast_r));
endmodule // mjp_panel
`default_nettype wire

// [tb/mjp_drive_model.sv]
`timescale 1ns/1ns
`default_nettype none
// axis drives: counts steps per axis and direction, keeps the latest step spacing
module mjp_drive_model import mjp_pkg::*; (
   input wire logic clk_in,
   input wire logic clr_in,
   input wire mjp_axis_t axis_in,
   output logic [3:0][15:0] cnt_out,
   output logic [31:0] gap_out
);
   logic [31:0] since_r;
   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         cnt_out <= '0;
         since_r <= '0;
         gap_out <= '0;
      end else begin
         since_r <= since_r + 32'h1;
         // index: bit 1 set for x, bit 0 set for toward
         if (axis_in.z_step) begin
            cnt_out[{1'b0, axis_in.z_toward}] <= cnt_out[{1'b0, axis_in.z_toward}] + 16'h1;
         end
         if (axis_in.x_step) begin
            cnt_out[{1'b1, axis_in.x_toward}] <= cnt_out[{1'b1, axis_in.x_toward}] + 16'h1;
         end
         if (axis_in.x_step | axis_in.z_step) begin
            gap_out <= since_r + 32'h1;
            since_r <= '0;
         end
      end
   end
endmodule // mjp_drive_model
`default_nettype wire

// [tb/manual_jog_and_override_panel_test.sv]
`timescale 1ns/1ns
`default_nettype none
module manual_jog_and_override_panel_test import mjp_pkg::*;;
   localparam int FAST = 20;
   localparam int SLOW = 40;
   localparam int REP = 16;
   localparam int RAMP = 8;
   localparam int K_START = 12;
   localparam int K_STOP = 11;
   localparam int K_MAN = 10;
   localparam int K_LEFT = 9;
   localparam int K_RIGHT = 8;
   localparam int K_FDEC = 5;
   localparam int K_FINC = 4;
   localparam int K_SDEC = 3;
   localparam int K_SINC = 2;
   localparam int K_SON = 1;
   localparam int K_SOFF = 0;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [12:0] kv = '0;
   // pulses: 0 sim request, 1 program end, 2 block done, 3 spindle load
   logic [3:0] pv = '0;
   logic [10:0] pf = 11'h032;
   logic clr = 1'b0;
   mjp_mode_t mode;
   mjp_disp_t disp;
   logic [10:0] feed;
   logic [11:0] spin;
   logic spin_on;
   logic sim_fast;
   mjp_axis_t axis;
   logic [3:0][15:0] cnt;
   logic [31:0] gap;
   int errors = 0;
   int tests_run = 0;

   mjp_panel #(.FAST_CYC(FAST), .SLOW_CYC(SLOW), .REPEAT_CYC(REP), .SPIN_RAMP_CYC(RAMP),
      .CW(24)) uut (.clk_in(clk), .resetn_in(resetn), .keys_in(mjp_keys_t'(kv)),
      .sim_req_in(pv[0]), .prog_end_in(pv[1]), .block_done_in(pv[2]),
      .spin_prog_load_in(pv[3]), .prog_feed_in(pf), .prog_spin_in(12'h3E8),
      .mode_out(mode), .disp_out(disp), .feed_out(feed), .spin_speed_out(spin),
      .spin_on_out(spin_on), .sim_fast_out(sim_fast), .axis_out(axis));
   mjp_drive_model drv (.clk_in(clk), .clr_in(clr), .axis_in(axis), .cnt_out(cnt),
      .gap_out(gap));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, g);
      end
   endtask

   task automatic hold(input int b, input int n);
      @(posedge clk) kv[b] <= 1'b1;
      repeat (n) @(posedge clk);
      kv[b] <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic pulse(input int b);
      @(posedge clk) pv[b] <= 1'b1;
      @(posedge clk) pv[b] <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic clear();
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic s_mode();
      hold(K_MAN, 1);
      chk("mode idle", M_IDLE, mode);
      hold(K_START, 1);
      hold(K_MAN, 1);
      chk("mode running", M_RUN, mode);
      hold(K_STOP, 1);
      chk("mode halted", M_HALT, mode);
      hold(K_START, 1);
      chk("mode resumed", M_RUN, mode);
      hold(K_STOP, 1);
      hold(K_MAN, 1);
      chk("mode manual", M_MANUAL, mode);
      chk("rate first", JOG_FAST, disp.rate);
      chk("manual shown", 1, disp.manual);
   endtask

   task automatic s_rate();
      int n;
      mjp_rate_t prev;
      hold(K_MAN, 1);
      chk("rate second", JOG_SLOW, disp.rate);
      hold(K_MAN, 1);
      chk("rate third", JOG_STEP, disp.rate);
      hold(K_MAN, 1);
      chk("rate wrap", JOG_FAST, disp.rate);
      n = 0;
      prev = disp.rate;
      @(posedge clk) kv[K_MAN] <= 1'b1;
      for (int i = 0; i < 45; i++) begin
         @(posedge clk);
         if (i == 40) kv[K_MAN] <= 1'b0;
         if (disp.rate !== prev) n++;
         prev = disp.rate;
      end
      chk("held advances", 3, n);
      chk("held rate", JOG_FAST, disp.rate);
   endtask

   task automatic s_step();
      hold(K_MAN, 1);
      hold(K_MAN, 1);
      // left, right, up, down land on counter 1, 0, 3, 2
      for (int i = 0; i < 4; i++) begin
         clear();
         hold(K_LEFT - i, 50);
         chk("step direction", 1, cnt[i ^ 1]);
         chk("step total", 1, cnt[0] + cnt[1] + cnt[2] + cnt[3]);
      end
   endtask

   task automatic s_cont();
      int p;
      logic [15:0] c;
      hold(K_MAN, 1);
      for (int r = 0; r < 2; r++) begin
         p = (r == 0) ? FAST : SLOW;
         clear();
         @(posedge clk) kv[K_RIGHT] <= 1'b1;
         repeat (3 * p - 1) @(posedge clk);
         @(negedge clk);
         chk("held spacing", p, gap);
         @(posedge clk) kv[K_RIGHT] <= 1'b0;
         repeat (31 * p - 1) @(posedge clk);
         @(negedge clk);
         chk("decel spacing", 16 * p, gap);
         c = cnt[0];
         repeat (32 * p) @(negedge clk);
         chk("stopped after release", c, cnt[0]);
         chk("away only", 0, cnt[1]);
         hold(K_MAN, 1);
      end
      hold(K_STOP, 1);
   endtask

   task automatic s_feed();
      hold(K_START, 1);
      chk("feed nominal", 11'h032, feed);
      for (int i = 0; i < 3; i++) hold(K_FINC, 1);
      chk("feed raised", 11'h037, feed);
      chk("shown override", 11'h032, disp.ovr_feed);
      chk("shown programmed", 11'h032, disp.prog_feed);
      chk("feed shown", 1, disp.feed_valid);
      pulse(2);
      chk("feed restored", 11'h032, feed);
      @(posedge clk) pf <= 11'h037;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("feed follows program", 11'h037, feed);
      chk("shown programmed tens", 11'h032, disp.prog_feed);
      @(posedge clk) pf <= 11'h032;
      hold(K_FDEC, 1);
      chk("feed lowered", 11'h02F, feed);
      for (int i = 0; i < 20; i++) hold(K_FDEC, 1);
      chk("feed floor", 11'h000, feed);
      pulse(2);
   endtask

   task automatic s_spin();
      logic [11:0] s;
      pulse(3);
      chk("spindle loaded", 12'h3E8, spin);
      hold(K_SON, 1);
      chk("spindle on", 1, spin_on);
      hold(K_SINC, 5 * RAMP);
      s = spin;
      chk("spindle raised", 1, (s > 12'h3E8) && (s <= 12'h424));
      repeat (5 * RAMP) @(negedge clk);
      chk("spindle kept", s, spin);
      chk("override not shown", 11'h032, disp.ovr_feed);
      hold(K_SDEC, 10 * RAMP);
      chk("spindle lowered", 1, spin < s);
      s = spin;
      repeat (5 * RAMP) @(negedge clk);
      chk("lowered kept", s, spin);
      hold(K_SOFF, 1);
      chk("spindle off", 0, spin_on);
      chk("program runs on", M_RUN, mode);
   endtask

   task automatic s_sim();
      pulse(1);
      pulse(0);
      chk("mode simulation", M_SIM, mode);
      hold(K_FINC, 1);
      chk("sim fast", 1, sim_fast);
      hold(K_FDEC, 1);
      chk("sim slow", 0, sim_fast);
      hold(K_STOP, 1);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (5) @(negedge clk);
      chk("reset mode", M_IDLE, mode);
      s_mode();
      s_rate();
      s_step();
      s_cont();
      s_feed();
      s_spin();
      s_sim();
      conclude();
   end

   // whole run needs roughly 5000 cycles
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      conclude();
   end
endmodule // manual_jog_and_override_panel_test
`default_nettype wire
